// ### include/owl_if.sv
`timescale 1ns/100ps
interface owl_if;
   logic dev_out;
   logic dev_oe_n;
   logic host_out;
   logic host_oe_n;
   logic line;
   // pull-up: the wire is low only while somebody pulls it low
   assign line = ((!dev_oe_n && !dev_out) || (!host_oe_n && !host_out))
                 ? 1'b0 : 1'b1;
   modport dev  (input line, output dev_out,  output dev_oe_n);
   modport host (input line, output host_out, output host_oe_n);
endinterface : owl_if

// ### include/owl_pkg.sv
package owl_pkg;
   // clock and link timing
   localparam int CLK_PERIOD_NS  = 8;
   localparam int WAKE_NS        = 30000;
   localparam int WAKE_CYC       = (WAKE_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
   localparam int PHASE_SLOW_US  = 500;
   localparam int PHASE_TYP_US   = 264;
   localparam int PHASE_FAST_US  = 160;
   localparam int PHASE_TYP_CYC  = PHASE_TYP_US * 1000 / CLK_PERIOD_NS;
   localparam int SLEEP_MS       = 2000;
   localparam int SLEEP_CYC      = SLEEP_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CNT_W          = 18;
   localparam int IDLE_W         = 28;
   // mode-select byte layout
   localparam int MODE_CIPHER_BIT = 7;
   localparam int MODE_DOUBLE_BIT = 6;
   localparam int MODE_FEED_BIT   = 4;
   localparam int MODE_DIGEST_BIT = 3;
   localparam int MODE_LOOP_LSB   = 0;
   localparam int MODE_LOOP_W     = 3;
   localparam logic [7:0] BYPASS_XOR = 8'h01;
   // framing
   localparam int SEED_BYTES   = 8;
   localparam int RESULT_BYTES = 10;
   localparam logic [3:0] NIBBLE_SLOT = 4'h4;
   localparam logic [3:0] LAST_SLOT   = 4'h9;
   localparam logic       DIR_READ    = 1'b1;
   // arbitrary address value, not tied to any product
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;
   // host transaction steps
   localparam logic [4:0] ST_ADDR      = 5'h03;
   localparam logic [4:0] ST_MODE      = 5'h04;
   localparam logic [4:0] ST_W_SEED0   = 5'h05;
   localparam logic [4:0] ST_W_END     = 5'h0D;
   localparam logic [4:0] ST_R_RESTART = 5'h05;
   localparam logic [4:0] ST_R_ADDR    = 5'h06;
   localparam logic [4:0] ST_R_RES0    = 5'h07;
   localparam logic [4:0] ST_R_END     = 5'h11;
   // host command registers
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_ADDR      = 8'h04;
   localparam logic [7:0] REG_MODE      = 8'h08;
   localparam logic [7:0] REG_PHASE     = 8'h0C;
   localparam logic [7:0] REG_STATUS    = 8'h10;
   localparam logic [7:0] REG_SEED_BASE = 8'h20;
   localparam logic [7:0] REG_RES_BASE  = 8'h40;
   localparam logic [7:0] REG_RES_END   = 8'h68;
   localparam int CTRL_GO_BIT   = 0;
   localparam int CTRL_READ_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_ERR_BIT  = 1;
   localparam int STAT_DONE_BIT = 2;
endpackage : owl_pkg

// ### rtl/owl_dev.sv
`timescale 1ns/100ps
module owl_dev
   import owl_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR     = DEV_ADDR_DEFAULT,
   parameter int         SLEEP_CYCLES = SLEEP_CYC
) (
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_rstn,
   owl_if.dev                          link,
   output logic                        o_cipher_master_enable,
   output logic                        o_double_pass_enable,
   output logic                        o_chained_feedback_enable,
   output logic                        o_digest_enable,
   output logic                        o_bypass,
   output logic [MODE_LOOP_W-1:0]      o_round_loop_count,
   output logic                        o_seed_valid,
   output logic [8*SEED_BYTES-1:0]     o_seed,
   input  wire logic [8*RESULT_BYTES-1:0] i_result,
   output logic                        o_sleep
);
   typedef enum logic [2:0] {
      DS_SLEEP, DS_WAKE, DS_PRE, DS_ACKP, DS_BYTE, DS_MUTE
   } owl_dstate_e;
   typedef enum logic [1:0] {K_ADDR, K_MODE, K_SEED, K_RESULT} owl_kind_e;

   owl_dstate_e      state;
   owl_kind_e        kind;
   logic             sync1;
   logic             line;
   logic             line_d;
   logic             drive;
   logic             second_pre;
   logic [3:0]       slot;
   logic [3:0]       idx;
   logic [7:0]       shift;
   logic [7:0]       tx_byte;
   logic [7:0]       mode_reg;
   logic [7:0]       seed_mem [SEED_BYTES];
   logic [CNT_W-1:0] ref_len;
   logic [CNT_W-1:0] low_cnt;
   logic [CNT_W:0]   high_cnt;
   logic [IDLE_W-1:0] idle_cnt;

   wire             fall     = line_d & ~line;
   wire             rise     = ~line_d & line;
   wire [CNT_W-1:0] bit_thr  = ref_len >> 3;
   wire [CNT_W-1:0] pre_thr  = ref_len >> 1;
   wire [CNT_W:0]   end_thr  = {1'b0, ref_len} + {2'b00, ref_len[CNT_W-1:1]};
   wire [CNT_W-1:0] hold     = (ref_len >> 3) + (ref_len >> 4);
   wire             rx_bit    = low_cnt > bit_thr;
   wire             is_marker = low_cnt > pre_thr;
   wire             is_end    = {1'b0, low_cnt} > end_thr;
   wire             is_hs     = (slot == NIBBLE_SLOT) || (slot == LAST_SLOT);
   wire [2:0]       data_pos  = (slot < NIBBLE_SLOT) ? slot[2:0]
                                : 3'(slot - 4'h1);
   wire             tx_bit    = tx_byte[3'h7 - data_pos];
   wire             byte_end  = (state == DS_BYTE) && rise && !is_marker
                                && (slot == LAST_SLOT);
   wire             seed_we   = byte_end && (kind == K_SEED)
                                && (idx < 4'(SEED_BYTES));
   // ack slots and read data are the only slots the device pulls low
   wire             dev_one   = (state == DS_ACKP)
                                || ((state == DS_BYTE)
                                && ((kind == K_RESULT) ? (!is_hs && tx_bit)
                                : is_hs));
   wire             addr_hit  = shift[7:1] == DEV_ADDR;

   // bypass bytes past the seed store carry the constant alone
   function automatic logic [7:0] res_byte(input logic [3:0] n);
      logic [7:0] r;
      r = 8'h00;
      if (!mode_reg[MODE_CIPHER_BIT]) begin
         if (n < 4'(SEED_BYTES)) begin
            r = seed_mem[n[2:0]] ^ BYPASS_XOR;
         end else begin
            r = BYPASS_XOR;
         end
      end else if (n < 4'(RESULT_BYTES)) begin
         r = i_result[8*(RESULT_BYTES-1-int'(n)) +: 8];
      end
      return r;
   endfunction : res_byte

   assign link.dev_out  = 1'b0;
   assign link.dev_oe_n = ~drive;

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         sync1  <= 1'b1;
         line   <= 1'b1;
         line_d <= 1'b1;
      end else begin
         sync1  <= link.line;
         line   <= sync1;
         line_d <= line;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         low_cnt  <= '0;
         high_cnt <= '0;
      end else begin
         if (fall) begin
            low_cnt <= CNT_W'(1);
         end else if (!line && (low_cnt != '1)) begin
            low_cnt <= low_cnt + CNT_W'(1);
         end
         if (rise) begin
            high_cnt <= (CNT_W+1)'(1);
         end else if (line && (high_cnt != '1)) begin
            high_cnt <= high_cnt + (CNT_W+1)'(1);
         end
      end
   end

   // the pull-down ends at three sixteenths of a phase from the slot edge
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         drive <= 1'b0;
      end else if (fall && dev_one) begin
         drive <= 1'b1;
      end else if (low_cnt >= hold) begin
         drive <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         idle_cnt <= '0;
         o_sleep  <= 1'b0;
      end else if ((state != DS_SLEEP) || !line) begin
         idle_cnt <= '0;
         o_sleep  <= 1'b0;
      end else if (idle_cnt != IDLE_W'(SLEEP_CYCLES)) begin
         idle_cnt <= idle_cnt + IDLE_W'(1);
      end else begin
         o_sleep <= 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (seed_we) begin
         seed_mem[idx[2:0]] <= shift;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         state        <= DS_SLEEP;
         kind         <= K_ADDR;
         second_pre   <= 1'b0;
         slot         <= '0;
         idx          <= '0;
         shift        <= '0;
         tx_byte      <= '0;
         mode_reg     <= '0;
         o_seed_valid <= 1'b0;
         ref_len      <= CNT_W'(PHASE_TYP_CYC);
      end else begin
         o_seed_valid <= 1'b0;
         case (state)
            DS_SLEEP: if (fall) begin
               state <= DS_WAKE;
            end
            DS_WAKE: if (rise) begin
               state      <= DS_PRE;
               second_pre <= 1'b0;
            end
            DS_PRE: if (rise) begin
               ref_len <= low_cnt;
               state   <= DS_ACKP;
            end
            DS_ACKP: if (rise) begin
               if (!second_pre) begin
                  second_pre <= 1'b1;
                  state      <= DS_PRE;
               end else begin
                  state <= DS_BYTE;
                  kind  <= K_ADDR;
                  slot  <= '0;
               end
            end
            DS_BYTE: if (rise) begin
               if (is_end) begin
                  state <= DS_SLEEP;
               end else if (is_marker) begin
                  ref_len    <= low_cnt;
                  second_pre <= 1'b1;
                  state      <= DS_ACKP;
               end else begin
                  if (!is_hs && (kind != K_RESULT)) begin
                     shift <= {shift[6:0], rx_bit};
                  end
                  slot <= (slot == LAST_SLOT) ? 4'h0 : slot + 4'h1;
               end
               if (byte_end) begin
                  case (kind)
                     K_ADDR: begin
                        if (!addr_hit) begin
                           state <= DS_MUTE;
                        end else if (shift[0] == DIR_READ) begin
                           kind    <= K_RESULT;
                           idx     <= 4'h0;
                           tx_byte <= res_byte(4'h0);
                        end else begin
                           kind <= K_MODE;
                        end
                     end
                     K_MODE: begin
                        mode_reg <= shift;
                        kind     <= K_SEED;
                        idx      <= 4'h0;
                     end
                     K_SEED: if (idx < 4'(SEED_BYTES)) begin
                        idx          <= idx + 4'h1;
                        o_seed_valid <= idx == 4'(SEED_BYTES - 1);
                     end
                     default: begin
                        idx     <= idx + 4'h1;
                        tx_byte <= res_byte(idx + 4'h1);
                     end
                  endcase
               end
            end
            default: if (high_cnt > {ref_len, 1'b0}) begin
               state <= DS_SLEEP;
            end
         endcase
      end
   end

   // sub-modes are independent gates on the master enable
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         o_cipher_master_enable    <= 1'b0;
         o_double_pass_enable      <= 1'b0;
         o_chained_feedback_enable <= 1'b0;
         o_digest_enable           <= 1'b0;
         o_bypass                  <= 1'b1;
         o_round_loop_count        <= '0;
      end else begin
         o_cipher_master_enable    <= mode_reg[MODE_CIPHER_BIT];
         o_double_pass_enable      <= mode_reg[MODE_CIPHER_BIT]
                                      & mode_reg[MODE_DOUBLE_BIT];
         o_chained_feedback_enable <= mode_reg[MODE_CIPHER_BIT]
                                      & mode_reg[MODE_FEED_BIT];
         o_digest_enable           <= mode_reg[MODE_CIPHER_BIT]
                                      & mode_reg[MODE_DIGEST_BIT];
         o_bypass                  <= ~mode_reg[MODE_CIPHER_BIT];
         o_round_loop_count <= mode_reg[MODE_LOOP_LSB +: MODE_LOOP_W];
      end
   end

   for (genvar g = 0; g < SEED_BYTES; g++) begin : g_seed
      assign o_seed[8*(SEED_BYTES-1-g) +: 8] = seed_mem[g];
   end
endmodule : owl_dev

// ### rtl/owl_host.sv
`timescale 1ns/100ps
module owl_host
   import owl_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_rstn,
   owl_if.host              link,
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [31:0]      o_rdata
);
   typedef enum logic [2:0] {
      HS_IDLE, HS_WAKE, HS_PHI, HS_PLO, HS_PGAP, HS_SLOT, HS_END, HS_GAP
   } owl_hstate_e;

   owl_hstate_e      state;
   logic             sync1;
   logic             line;
   logic             pull;
   logic             rd_op;
   logic             ack_err;
   logic             done;
   logic [4:0]       step;
   logic [3:0]       slot;
   logic [CNT_W+1:0] cnt;
   logic [7:0]       rx_shift;
   logic [6:0]       dev_addr;
   logic [7:0]       mode;
   logic [CNT_W-1:0] phase;
   logic [7:0]       seed_mem [SEED_BYTES];
   logic [7:0]       res_mem [RESULT_BYTES];
   logic [31:0]      rd_mux;

   wire [CNT_W-1:0] q4   = phase >> 2;
   wire [CNT_W-1:0] q8   = phase >> 3;
   wire [CNT_W-1:0] q16  = phase >> 4;
   wire [CNT_W+1:0] ph1  = {2'b00, phase};
   wire [CNT_W+1:0] ph2  = {1'b0, phase, 1'b0};
   wire [CNT_W+1:0] ph3  = ph2 + ph1;
   wire [4:0]       last = rd_op ? ST_R_END : ST_W_END;
   wire [4:0]       nstep = step + 5'h01;
   wire             el_pre = (step == 5'h01) || (step == 5'h02)
                             || (rd_op && (step == ST_R_RESTART));
   wire             nx_pre = (nstep == 5'h02)
                             || (rd_op && (nstep == ST_R_RESTART));
   wire             el_rx  = rd_op && (step >= ST_R_RES0);
   wire             is_hs  = (slot == NIBBLE_SLOT) || (slot == LAST_SLOT);
   wire [2:0]       d_pos  = (slot < NIBBLE_SLOT) ? slot[2:0]
                             : 3'(slot - 4'h1);
   wire [2:0]       s_idx  = 3'(step - ST_W_SEED0);
   wire [3:0]       r_idx  = 4'(step - ST_R_RES0);
   wire [7:0]       tx_byte = (step == ST_ADDR) ? {dev_addr, ~DIR_READ}
                            : (step == ST_MODE) ? mode
                            : (rd_op && (step == ST_R_ADDR))
                              ? {dev_addr, DIR_READ}
                            : seed_mem[s_idx];
   // the host writes a one as a long low, including read-side sync
   wire             host_one = !el_pre && (is_hs ? el_rx
                               : (!el_rx && tx_byte[3'h7 - d_pos]));
   wire             exp_one  = el_pre || (is_hs && !el_rx);
   wire [CNT_W-1:0] lo_end   = host_one ? (q8 + q16) : q16;
   wire [CNT_W+1:0] q4_end   = {2'b00, q4} - 1'b1;
   wire             slot_end = (state == HS_SLOT) && (cnt == q4_end);
   wire             byte_fin = slot_end && (el_pre || (slot == LAST_SLOT));
   wire             res_we   = byte_fin && el_rx && !el_pre;
   wire             start    = i_wr && (i_addr == REG_CTRL)
                               && i_wdata[CTRL_GO_BIT] && (state == HS_IDLE);
   wire             seed_hit = i_addr[7:5] == REG_SEED_BASE[7:5];
   wire             res_hit  = (i_addr >= REG_RES_BASE)
                               && (i_addr < REG_RES_END);
   wire [3:0]       res_sel  = 4'((i_addr - REG_RES_BASE) >> 2);
   wire             next_pull = (state == HS_WAKE) || (state == HS_PLO)
                               || (state == HS_END)
                               || ((state == HS_SLOT)
                               && (cnt < {2'b00, lo_end}));

   assign link.host_out  = 1'b0;
   assign link.host_oe_n = ~pull;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (i_addr == REG_CTRL) begin
         rd_mux[CTRL_READ_BIT] = rd_op;
      end else if (i_addr == REG_ADDR) begin
         rd_mux[6:0] = dev_addr;
      end else if (i_addr == REG_MODE) begin
         rd_mux[7:0] = mode;
      end else if (i_addr == REG_PHASE) begin
         rd_mux[CNT_W-1:0] = phase;
      end else if (i_addr == REG_STATUS) begin
         rd_mux[STAT_BUSY_BIT] = state != HS_IDLE;
         rd_mux[STAT_ERR_BIT]  = ack_err;
         rd_mux[STAT_DONE_BIT] = done;
      end else if (seed_hit && !i_addr[1] && !i_addr[0]) begin
         rd_mux[7:0] = seed_mem[i_addr[4:2]];
      end else if (res_hit) begin
         rd_mux[7:0] = res_mem[res_sel];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         o_rdata <= rd_mux;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         sync1 <= 1'b1;
         line  <= 1'b1;
         pull  <= 1'b0;
      end else begin
         sync1 <= link.line;
         line  <= sync1;
         pull  <= next_pull;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         dev_addr <= DEV_ADDR_DEFAULT;
         mode     <= 8'h00;
         phase    <= CNT_W'(PHASE_TYP_CYC);
      end else if (i_wr) begin
         if (i_addr == REG_ADDR) begin
            dev_addr <= i_wdata[6:0];
         end else if (i_addr == REG_MODE) begin
            mode <= i_wdata[7:0];
         end else if (i_addr == REG_PHASE) begin
            phase <= i_wdata[CNT_W-1:0];
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_wr && seed_hit) begin
         seed_mem[i_addr[4:2]] <= i_wdata[7:0];
      end
      if (res_we) begin
         res_mem[r_idx] <= rx_shift;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         state    <= HS_IDLE;
         rd_op    <= 1'b0;
         ack_err  <= 1'b0;
         done     <= 1'b0;
         step     <= '0;
         slot     <= '0;
         cnt      <= '0;
         rx_shift <= '0;
      end else begin
         cnt <= cnt + 1'b1;
         case (state)
            HS_IDLE: begin
               cnt <= '0;
               if (start) begin
                  rd_op   <= i_wdata[CTRL_READ_BIT];
                  ack_err <= 1'b0;
                  done    <= 1'b0;
                  step    <= '0;
                  state   <= HS_WAKE;
               end
            end
            HS_WAKE: if (cnt == (CNT_W+2)'(WAKE_CYC - 1)) begin
               cnt   <= '0;
               step  <= 5'h01;
               state <= HS_PHI;
            end
            HS_PHI: if (cnt == ph1 - 1'b1) begin
               cnt   <= '0;
               state <= HS_PLO;
            end
            HS_PLO: if (cnt == ph1 - 1'b1) begin
               cnt   <= '0;
               slot  <= '0;
               state <= HS_PGAP;
            end
            // without this release the ack slot merges into the low phase
            HS_PGAP: if (cnt == q4_end) begin
               cnt   <= '0;
               state <= HS_SLOT;
            end
            HS_SLOT: begin
               if (cnt == {2'b00, q8}) begin
                  if (exp_one && line) begin
                     ack_err <= 1'b1;
                  end
                  if (el_rx && !is_hs) begin
                     rx_shift <= {rx_shift[6:0], ~line};
                  end
               end
               if (slot_end) begin
                  cnt  <= '0;
                  slot <= slot + 4'h1;
               end
               if (byte_fin) begin
                  step  <= nstep;
                  slot  <= '0;
                  state <= (nstep == last) ? HS_END
                           : nx_pre ? HS_PHI : HS_SLOT;
               end
            end
            HS_END: if (cnt == ph2 - 1'b1) begin
               cnt   <= '0;
               state <= HS_GAP;
            end
            default: if (cnt == ph3 - 1'b1) begin
               done  <= 1'b1;
               state <= HS_IDLE;
            end
         endcase
      end
   end
endmodule : owl_host

// ### sim/owl_asserts.sv
`timescale 1ns/100ps
module owl_asserts (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic dev_out,
   input wire logic dev_oe_n,
   input wire logic host_out,
   input wire logic host_oe_n,
   input wire logic line
);
   // bounds assume the bench phase of 128 cycles
   localparam int MAX_LOW = 3800;
   logic [11:0] low_cnt;
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn || line) begin
         low_cnt <= 12'h000;
      end else if (low_cnt != 12'hFFF) begin
         low_cnt <= low_cnt + 12'h001;
      end
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   a_dev_drv_low: assert property (dev_out == 1'b0)
      else $error("device drives line high");
   a_host_drv_low: assert property (host_out == 1'b0)
      else $error("host drives line high");
   a_rst_release: assert property (
      !$past(i_rstn) |-> dev_oe_n && host_oe_n)
      else $error("line pulled right after reset");
   a_dev_reacts: assert property ($fell(dev_oe_n) |-> $past(!line))
      else $error("device starts a low on idle line");
   a_dev_ack_len: assert property (!dev_oe_n |-> low_cnt <= 12'h020)
      else $error("device pull too long");
   a_dev_release: assert property ($fell(dev_oe_n) |-> ##[1:32] dev_oe_n)
      else $error("device pull not released");
   a_host_low_min: assert property ($fell(host_oe_n) |-> !host_oe_n[*6])
      else $error("host low too short");
   a_host_high_min: assert property ($rose(host_oe_n) |-> host_oe_n[*6])
      else $error("host high too short");
   a_low_bounded: assert property (low_cnt <= MAX_LOW)
      else $error("line held low too long");
   cover property ($fell(dev_oe_n));
   cover property (low_cnt == 12'hE74);
   cover property (low_cnt == 12'h0FA);
endmodule : owl_asserts

// ### sim/tb.sv
`timescale 1ns/100ps
module tb;
   import owl_pkg::*;
   logic        i_sys_clk = 1'b0;
   logic        i_rstn, i_wr, i_rd, cme, dpe, cfe, dge, byp, sv, slp;
   logic [7:0]  i_addr;
   logic [31:0] i_wdata, o_rdata, rv;
   logic [79:0] i_result;
   logic [63:0] o_seed, seed_q;
   logic [2:0]  loop;
   int          n_errors, n_checks, n_sv;
   owl_if lnk ();
   owl_dev #(.SLEEP_CYCLES(2000)) u_owl_dev (.i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn), .link(lnk.dev), .o_cipher_master_enable(cme),
      .o_double_pass_enable(dpe), .o_chained_feedback_enable(cfe),
      .o_digest_enable(dge), .o_bypass(byp), .o_round_loop_count(loop),
      .o_seed_valid(sv), .o_seed(o_seed), .i_result(i_result),
      .o_sleep(slp));
   owl_host u_owl_host (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
      .link(lnk.host), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata));
   owl_asserts u_owl_asserts (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
      .dev_out(lnk.dev_out), .dev_oe_n(lnk.dev_oe_n),
      .host_out(lnk.host_out), .host_oe_n(lnk.host_oe_n), .line(lnk.line));
   always #4 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      if (sv === 1'b1) n_sv++;
   end
   task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge i_sys_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1 rv = o_rdata;
   endtask : rd
   task automatic run(input logic [7:0] m, input logic op, input logic er);
      wr(REG_MODE, {24'h0, m});
      wr(REG_CTRL, {30'h0, op, 1'b1});
      rv = 32'h1;
      for (int i = 0; i < 6000 && rv[0] !== 1'b0; i++) rd(REG_STATUS);
      chk(rv[2:0], {1'b1, er, 1'b0});
   endtask : run
   task automatic t_write(input logic [7:0] m);
      int s;
      s = n_sv;
      for (int n = 0; n < SEED_BYTES; n++) begin
         seed_q[63-8*n -: 8] = m + 8'(8'h11 * n);
         wr(REG_SEED_BASE + 8'(4*n), {24'h0, seed_q[63-8*n -: 8]});
      end
      run(m, 1'b0, 1'b0);
      chk(o_seed, seed_q);
      chk(n_sv - s, 1);
      chk({cme, dpe, cfe, dge, byp, loop}, {m[7], m[7] & m[6], m[7] & m[4],
          m[7] & m[3], !m[7], m[2:0]});
   endtask : t_write
   task automatic t_read(input logic [7:0] m);
      logic [7:0] e;
      run(m, 1'b1, 1'b0);
      for (int n = 0; n < RESULT_BYTES; n++) begin
         e = (n < SEED_BYTES ? seed_q[63-8*n -: 8] : 8'h00) ^ BYPASS_XOR;
         if (m[7]) e = i_result[79-8*n -: 8];
         rd(REG_RES_BASE + 8'(4*n));
         chk(rv[7:0], e);
      end
   endtask : t_read
   task automatic t_wrong();
      int s;
      s = n_sv;
      wr(REG_ADDR, 32'h11);
      run(8'h25, 1'b0, 1'b1);
      chk(n_sv - s, 0);
      chk(o_seed, seed_q);
      wr(REG_ADDR, {25'h0, DEV_ADDR_DEFAULT});
   endtask : t_wrong
   task automatic t_reset();
      rd(REG_ADDR);
      chk(rv, {25'h0, DEV_ADDR_DEFAULT});
      rd(8'h7C);
      chk(rv, 32'h0);
      chk({byp, cme, slp}, 3'h4);
   endtask : t_reset
   task automatic t_sleep();
      repeat (2600) @(posedge i_sys_clk);
      chk(slp, 1'b1);
      t_write(8'hC1);
      chk(slp, 1'b0);
   endtask : t_sleep
   task automatic stop_test();
      if (n_errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test
   initial begin
      #(8 * 100000);
      n_errors++;
      stop_test();
   end
   initial begin
      {i_rstn, i_wr, i_rd, i_addr, i_wdata} = '0;
      i_result = 80'h0123456789ABCDEF5AA5;
      repeat (3) @(posedge i_sys_clk);
      i_rstn <= 1'b1;
      t_reset();
      // short phase keeps every frame within the run budget
      wr(REG_PHASE, 32'h80);
      foreach (seed_q[i]) seed_q[i] = 1'b0;
      t_write(8'hFF);
      t_write(8'h5A);
      t_write(8'hC1);
      t_write(8'h96);
      t_read(8'hFF);
      t_write(8'h25);
      t_read(8'h25);
      t_wrong();
      t_sleep();
      stop_test();
   end
endmodule : tb
